// [remote_temp_regs.sv]
// remote diode temperature result registers with high-then-low reading
`include "remote_temp_map.svh"
`default_nettype none
module remote_temp_regs (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire remote_temp_pkg::raw_temp_t conv_temp_in,
  input wire logic conv_valid_in,
  input wire logic filter_enable_in,
  input wire remote_temp_pkg::reg_req_t reg_req_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic extended_resolution_enable_out
);
  remote_temp_pkg::temp_bytes_t formatted;
  remote_temp_pkg::temp_bytes_t result;
  logic [7:0] signed_low_shadow;
  logic [7:0] unsigned_low_shadow;
  logic [7:0] enh_config;
  logic [7:0] next_rd_data;
  logic [7:0] rd_addr_q;
  logic extended_resolution_enable;

  assign extended_resolution_enable = enh_config[`EXT_RES_BIT];

  temp_format u_format (
    .raw_in(conv_temp_in),
    .filter_enable_in(filter_enable_in),
    .extended_resolution_enable_in(extended_resolution_enable),
    .bytes_out(formatted)
  );

  // all four bytes move on the same edge so formats never disagree
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      result <= '0;
    end else if (conv_valid_in) begin
      result <= formatted;
    end
  end

  // enhanced configuration: only the resolution enable is kept here
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      enh_config <= `ENH_CONFIG_RESET;
    end else if (reg_req_in.wr && reg_req_in.addr == `REG_ENH_CONFIG) begin
      enh_config <= `ZERO_BYTE;
      enh_config[`EXT_RES_BIT] <= reg_req_in.wdata[`EXT_RES_BIT];
    end
  end

  // a conversion landing between the two reads cannot tear the pair
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      signed_low_shadow <= `ZERO_BYTE;
    end else if (reg_req_in.rd && reg_req_in.addr == `REG_SIGNED_HIGH) begin
      signed_low_shadow <= result.signed_low;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      unsigned_low_shadow <= `ZERO_BYTE;
    end else if (reg_req_in.rd &&
                 reg_req_in.addr == `REG_UNSIGNED_HIGH) begin
      unsigned_low_shadow <= result.unsigned_low;
    end
  end

  // low bytes come from the shadow, so only high-first reads are coherent
  always_comb begin
    unique case (reg_req_in.addr)
      `REG_SIGNED_HIGH: next_rd_data = result.signed_high;
      `REG_SIGNED_LOW: next_rd_data = signed_low_shadow;
      `REG_UNSIGNED_HIGH: next_rd_data = result.unsigned_high;
      `REG_UNSIGNED_LOW: next_rd_data = unsigned_low_shadow;
      `REG_ENH_CONFIG: next_rd_data = enh_config;
      default: next_rd_data = `ZERO_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_out <= `ZERO_BYTE;
      rd_valid_out <= 1'b0;
      rd_addr_q <= `ZERO_BYTE;
    end else begin
      rd_valid_out <= reg_req_in.rd;
      if (reg_req_in.rd) begin
        rd_data_out <= next_rd_data;
        rd_addr_q <= reg_req_in.addr;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      extended_resolution_enable_out <= 1'b0;
    end else begin
      extended_resolution_enable_out <= extended_resolution_enable;
    end
  end

  // checks
  sequence s_read_signed_high;
    reg_req_in.rd && reg_req_in.addr == `REG_SIGNED_HIGH;
  endsequence

  sequence s_read_signed_low;
    reg_req_in.rd && reg_req_in.addr == `REG_SIGNED_LOW;
  endsequence

  sequence s_read_unsigned_high;
    reg_req_in.rd && reg_req_in.addr == `REG_UNSIGNED_HIGH;
  endsequence

  sequence s_read_unsigned_low;
    reg_req_in.rd && reg_req_in.addr == `REG_UNSIGNED_LOW;
  endsequence

  a_low_unused_zero: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    rd_valid_out && (rd_addr_q == `REG_SIGNED_LOW ||
                     rd_addr_q == `REG_UNSIGNED_LOW)
    |-> rd_data_out[`HIGH_LSB-3:0] == `LOW_UNUSED_ZERO)
    else $error("unused low-byte bits not zero");

  a_signed_pair_coherent: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    s_read_signed_high ##1
      (!(reg_req_in.rd && reg_req_in.addr == `REG_SIGNED_HIGH))[*3] ##1
      s_read_signed_low
    |=> rd_data_out == $past(result.signed_low, 5))
    else $error("signed low byte not from the latched pair");

  a_signed_shadow_take: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    s_read_signed_high |=> signed_low_shadow == $past(result.signed_low))
    else $error("signed low byte not latched on high read");

  a_unsigned_shadow_take: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    s_read_unsigned_high |=>
      unsigned_low_shadow == $past(result.unsigned_low))
    else $error("unsigned low byte not latched on high read");

  a_unsigned_low_read: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    s_read_unsigned_low |=> rd_valid_out &&
      rd_data_out == $past(unsigned_low_shadow))
    else $error("unsigned low read did not return the latched byte");

  a_formats_together: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    conv_valid_in |=> result == $past(formatted))
    else $error("formats not updated from one conversion");

  a_extra_over_limit: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    conv_valid_in && !filter_enable_in && extended_resolution_enable &&
    $signed(conv_temp_in) > $signed(`SIGNED_MAX)
    |=> result.signed_low[`EXTRA_MSB+3:3] == `EXTRA_ONES &&
        result.signed_high == `SIGNED_MAX >> 5)
    else $error("over-range signed extra bits not 11");

  a_signed_extra_plain: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    conv_valid_in && !filter_enable_in && !extended_resolution_enable
    |=> result.signed_low[`EXTRA_MSB+3:3] == `EXTRA_ZERO)
    else $error("signed extra bits not 00 at plain resolution");

  a_unsigned_extra_off: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    conv_valid_in && !filter_enable_in
    |=> result.unsigned_low[`EXTRA_MSB+3:3] == `EXTRA_ZERO)
    else $error("unsigned extra bits not 00 with filter off");

  a_unsigned_extra_on: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    conv_valid_in && filter_enable_in && !conv_temp_in[`RAW_SIGN_BIT]
    |=> result.unsigned_low[`EXTRA_MSB+3:3] == $past(conv_temp_in[1:0]))
    else $error("unsigned extra bits do not follow the reading");

  a_unsigned_high_value: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    conv_valid_in && !conv_temp_in[`RAW_SIGN_BIT]
    |=> result.unsigned_high == $past(conv_temp_in[`HIGH_MSB:`HIGH_LSB]))
    else $error("unsigned high byte wrong");

  a_ext_res_write: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    reg_req_in.wr && reg_req_in.addr == `REG_ENH_CONFIG
    |=> extended_resolution_enable == $past(reg_req_in.wdata[`EXT_RES_BIT])
    ##1 extended_resolution_enable_out == $past(extended_resolution_enable))
    else $error("extended resolution enable not taken from write");
endmodule
`default_nettype wire

// [remote_temp_map.svh]
// register offsets, field positions and constants of the remote reading
`ifndef REMOTE_TEMP_MAP_SVH
`define REMOTE_TEMP_MAP_SVH
`define REG_SIGNED_HIGH 8'h01
`define REG_SIGNED_LOW 8'h10
`define REG_UNSIGNED_HIGH 8'h31
`define REG_UNSIGNED_LOW 8'h32
`define REG_ENH_CONFIG 8'h45
`define EXT_RES_BIT 2
`define ENH_CONFIG_RESET 8'h00
`define ZERO_BYTE 8'h00
`define LOW_UNUSED_ZERO 3'h0
`define EXTRA_ZERO 2'h0
`define EXTRA_ONES 2'h3
`define SIGNED_MAX 14'h0FFC
`define SIGNED_MIN 14'h3000
`define UNSIGNED_ZERO 13'h0000
`define RAW_SIGN_BIT 13
`define HIGH_MSB 12
`define HIGH_LSB 5
`define FRAC_MSB 4
`define FRAC_LSB 2
`define EXTRA_MSB 1
`endif

// [remote_temp_pkg.sv]
// types shared by the remote temperature result registers
`default_nettype none
package remote_temp_pkg;
  // raw reading: signed, 1/32 degree C per count
  typedef logic [13:0] raw_temp_t;
  typedef struct packed {
    logic [7:0] signed_high;
    logic [7:0] signed_low;
    logic [7:0] unsigned_high;
    logic [7:0] unsigned_low;
  } temp_bytes_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage
`default_nettype wire

// [temp_format.sv]
// turns one raw reading into the signed and unsigned register bytes
`include "remote_temp_map.svh"
`default_nettype none
module temp_format (
  input wire remote_temp_pkg::raw_temp_t raw_in,
  input wire logic filter_enable_in,
  input wire logic extended_resolution_enable_in,
  output remote_temp_pkg::temp_bytes_t bytes_out
);
  logic [13:0] sv;
  logic [12:0] uv;
  logic over;
  logic [1:0] signed_temp_extra_fraction;
  logic [1:0] unsigned_temp_extra_fraction;

  function automatic logic [7:0] make_low(input logic [2:0] frac,
                                          input logic [1:0] extra);
    make_low = {frac, extra, `LOW_UNUSED_ZERO};
  endfunction

  always_comb begin
    over = $signed(raw_in) > $signed(`SIGNED_MAX);
    // signed form saturates at its 8.3 range
    if (over) begin
      sv = `SIGNED_MAX;
    end else if ($signed(raw_in) < $signed(`SIGNED_MIN)) begin
      sv = `SIGNED_MIN;
    end else begin
      sv = raw_in;
    end
    // unsigned form cannot show below zero
    if (raw_in[`RAW_SIGN_BIT]) begin
      uv = `UNSIGNED_ZERO;
    end else begin
      uv = raw_in[`HIGH_MSB:0];
    end
    if (filter_enable_in && extended_resolution_enable_in) begin
      signed_temp_extra_fraction = sv[`EXTRA_MSB:0];
    end else if (!filter_enable_in && extended_resolution_enable_in &&
                 over) begin
      signed_temp_extra_fraction = `EXTRA_ONES;
    end else begin
      signed_temp_extra_fraction = `EXTRA_ZERO;
    end
    if (filter_enable_in) begin
      unsigned_temp_extra_fraction = uv[`EXTRA_MSB:0];
    end else begin
      unsigned_temp_extra_fraction = `EXTRA_ZERO;
    end
    bytes_out.signed_high = sv[`HIGH_MSB:`HIGH_LSB];
    bytes_out.signed_low = make_low(sv[`FRAC_MSB:`FRAC_LSB],
                                    signed_temp_extra_fraction);
    bytes_out.unsigned_high = uv[`HIGH_MSB:`HIGH_LSB];
    bytes_out.unsigned_low = make_low(uv[`FRAC_MSB:`FRAC_LSB],
                                      unsigned_temp_extra_fraction);
  end
endmodule
`default_nettype wire

// [temp_host_model.sv]
// management-bus host model issuing register reads and writes
`default_nettype none
module temp_host_model (
  input wire logic sys_clk_in,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in,
  output remote_temp_pkg::reg_req_t req_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req_out = '0;
  // idle address and data are inverted so stale values never match
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge sys_clk_in);
    req_out = '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
    @(negedge sys_clk_in);
    req_out = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
  endtask
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
      output logic ok);
    @(negedge sys_clk_in);
    req_out = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
    @(negedge sys_clk_in);
    // valid stands for one cycle only, so take data while it is up
    data = rd_data_in;
    ok = rd_valid_in;
    req_out = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: 8'hFF};
  endtask
  // high byte always fetched first
  task automatic read_pair(input logic [7:0] hi_addr,
      input logic [7:0] lo_addr,
      output logic [7:0] hi, output logic [7:0] lo);
    logic ok;
    read_reg(hi_addr, hi, ok);
    read_reg(lo_addr, lo, ok);
  endtask
endmodule
`default_nettype wire

// [remote_temp_regs_tb.sv]
// testbench for the remote temperature result registers
`include "remote_temp_map.svh"
`default_nettype none
module remote_temp_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  remote_temp_pkg::raw_temp_t conv_temp_in = '0;
  logic conv_valid_in = 1'b0;
  logic filter_enable_in = 1'b0;
  remote_temp_pkg::reg_req_t reg_req;
  logic [7:0] rd_data;
  logic rd_valid;
  logic ext_en;
  int miscompares = 0;
  int tests_run = 0;
  logic [13:0] raws [6] = '{14'h0000, 14'h0FFC, 14'h0FE3, 14'h12C0,
    14'h3E70, 14'h2000};
  always #50 sys_clk_in = ~sys_clk_in;
  remote_temp_regs uut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .conv_temp_in(conv_temp_in), .conv_valid_in(conv_valid_in),
    .filter_enable_in(filter_enable_in), .reg_req_in(reg_req),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .extended_resolution_enable_out(ext_en));
  temp_host_model host (.sys_clk_in(sys_clk_in), .rd_data_in(rd_data),
    .rd_valid_in(rd_valid), .req_out(reg_req));
  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    tests_run++;
    if (seen !== expected) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, expected);
    end
  endtask
  task automatic stop_test;
    $display("compares=%0d mismatches=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic convert(input logic [13:0] raw);
    @(negedge sys_clk_in);
    conv_temp_in = raw;
    conv_valid_in = 1'b1;
    @(negedge sys_clk_in);
    conv_valid_in = 1'b0;
    conv_temp_in = ~raw;
  endtask
  // saturated signed reading with extended resolution and filter off assumed at max fraction
  function automatic remote_temp_pkg::temp_bytes_t expect_bytes(
      input logic [13:0] raw, input logic filt, input logic ext);
    remote_temp_pkg::temp_bytes_t b;
    logic [1:0] sx;
    sx = (filt && ext) ? raw[1:0] : 2'h0;
    if (ext && !filt && $signed(raw) > 14'sh0FFC) sx = 2'h3;
    b.signed_high = raw[12:5];
    b.signed_low = {raw[4:2], sx, 3'h0};
    // saturated value is exactly 127.875, so filtered extra bits are 00
    if ($signed(raw) > 14'sh0FFC) begin
      b.signed_high = 8'h7F;
      b.signed_low = {3'h7, (ext && !filt) ? 2'h3 : 2'h0, 3'h0};
    end
    if ($signed(raw) < 14'sh3000) begin
      b.signed_high = 8'h80;
      b.signed_low = 8'h00;
    end
    b.unsigned_high = raw[13] ? 8'h00 : raw[12:5];
    b.unsigned_low = raw[13] ? 8'h00 :
      {raw[4:2], filt ? raw[1:0] : 2'h0, 3'h0};
    return b;
  endfunction
  initial begin : main
    remote_temp_pkg::temp_bytes_t e;
    logic [7:0] hi;
    logic [7:0] lo;
    logic ok;
    repeat (8) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rstn_in = 1'b1;
    host.read_pair(`REG_SIGNED_HIGH, `REG_SIGNED_LOW, hi, lo);
    check(hi, `ZERO_BYTE);
    check(lo, `ZERO_BYTE);
    // only the enable bit survives; writes elsewhere are dropped
    host.write_reg(`REG_ENH_CONFIG, 8'hFF);
    host.write_reg(`REG_SIGNED_HIGH, 8'h55);
    host.read_reg(`REG_ENH_CONFIG, hi, ok);
    check(hi, 8'h04);
    check({7'h00, ext_en}, 8'h01);
    check({7'h00, ok}, 8'h01);
    host.read_reg(8'h7E, hi, ok);
    check(hi, `ZERO_BYTE);
    host.read_reg(`REG_SIGNED_HIGH, hi, ok);
    check(hi, `ZERO_BYTE);
    for (int m = 0; m < 4; m++) begin
      host.write_reg(`REG_ENH_CONFIG, m[1] ? 8'h04 : 8'h00);
      filter_enable_in = m[0];
      foreach (raws[i]) begin
        e = expect_bytes(raws[i], m[0], m[1]);
        convert(raws[i]);
        host.read_pair(`REG_SIGNED_HIGH, `REG_SIGNED_LOW, hi, lo);
        check(hi, e.signed_high);
        check(lo, e.signed_low);
        host.read_pair(`REG_UNSIGNED_HIGH, `REG_UNSIGNED_LOW, hi, lo);
        check(hi, e.unsigned_high);
        check(lo, e.unsigned_low);
      end
    end
    // a newer conversion between high and low must not tear the pair
    convert(14'h0C3F);
    host.read_reg(`REG_SIGNED_HIGH, hi, ok);
    convert(14'h0FE3);
    host.read_reg(`REG_SIGNED_LOW, lo, ok);
    e = expect_bytes(14'h0C3F, 1'b1, 1'b1);
    check(hi, e.signed_high);
    check(lo, e.signed_low);
    stop_test();
  end
  initial begin : watchdog
    #3000000;
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire
